// File: hdl/pdcw_params.svh
`ifndef PDCW_PARAMS_SVH
`define PDCW_PARAMS_SVH

// word geometry
`define PDCW_WORD_W 40
`define PDCW_BYTES 5

// field positions within the control word
`define PDCW_DAC_PD_BIT 39
`define PDCW_BGAP_PD_BIT 33
`define PDCW_INT_RSET_BIT 32
`define PDCW_RISE_HI 31
`define PDCW_RISE_LO 29
`define PDCW_FALL_HI 28
`define PDCW_FALL_LO 26
`define PDCW_LOCK_EN_BIT 25
`define PDCW_LOCK_MODE_BIT 24
`define PDCW_RFDIV_PD_BIT 23
`define PDCW_RFDIV_HI 22
`define PDCW_RFDIV_LO 21
`define PDCW_DRV_PD_BIT 20
`define PDCW_DRV_SEL_HI 19
`define PDCW_DRV_SEL_LO 18
`define PDCW_SLEW_DIS_BIT 17
`define PDCW_SYS_SRC_BIT 16
`define PDCW_FB_DIV_HI 15
`define PDCW_FB_DIV_LO 12
`define PDCW_REF_DIV_HI 11
`define PDCW_REF_DIV_LO 8
`define PDCW_OPEN_HI 7
`define PDCW_OPEN_LO 6
`define PDCW_CP_POL_BIT 5
`define PDCW_CP_FULL_PD_BIT 4
`define PDCW_CP_QUICK_PD_BIT 3
`define PDCW_CP_SCALE_HI 2
`define PDCW_CP_SCALE_LO 0

// reset value: rf divide code 11, driver powered down, driver fed by divider output
`define PDCW_RESET_VALUE 40'h00_0078_0000

// mask of bits that exist; open positions always read zero
`define PDCW_IMPL_MASK 40'h83_ffff_ff3f

`endif

// File: hdl/pdcw_pkg.sv
package pdcw_pkg;

  typedef enum logic [1:0] {
    PDCW_RDIV_1 = 2'b00,
    PDCW_RDIV_2 = 2'b01,
    PDCW_RDIV_4 = 2'b10,
    PDCW_RDIV_8 = 2'b11
  } pdcw_rdiv_t;

  typedef enum logic [1:0] {
    PDCW_DRV_NONE = 2'b00,
    PDCW_DRV_FB = 2'b01,
    PDCW_DRV_RFOUT = 2'b10,
    PDCW_DRV_RFIN = 2'b11
  } pdcw_drv_sel_t;

  // analog control bundle derived from the control word
  typedef struct packed {
    logic dac_pd;
    logic bgap_pd;
    logic int_rset;
    logic [2:0] rise_boost;
    logic [2:0] fall_boost;
    logic rfdiv_pd;
    logic [3:0] rf_ratio;
    logic drv_pd;
    logic drv_run;
    pdcw_drv_sel_t drv_sel;
    logic surge_en;
    logic sys_src_bypass;
    logic [4:0] fb_ratio;
    logic [4:0] ref_ratio;
    logic cp_invert;
    logic cp_pd;
    logic cp_out_en;
    logic [3:0] cp_mult;
  } pdcw_ctrl_t;

  // serial-side write port
  typedef struct packed {
    logic byte_vld;
    logic frame_end;
    logic [7:0] data;
  } pdcw_wr_t;

endpackage : pdcw_pkg

// File: hdl/pdcw_ratio_dec.sv
`timescale 1ns/1ns
// divide-ratio decoder: ratio = code + 1
module pdcw_ratio_dec #(
  parameter int CODE_W = 4
) (
  input wire logic [CODE_W-1:0] code_i,
  output logic [CODE_W:0] ratio_o
);

  always_comb
  begin
    ratio_o = {1'b0, code_i} + {{CODE_W{1'b0}}, 1'b1};
  end

endmodule : pdcw_ratio_dec

// File: hdl/pdcw_clock_path.sv
`timescale 1ns/1ns
`include "pdcw_params.svh"
// Function
// - lock enable drives shared status pin
// - status mode: 0 locked, 1 unlocked
// - lead-lag mode: 1 lag, 0 lead
// - rf divider powerdown enables alternate path
// - rf ratio codes 3,2,1,0 select 8,4,2,1
// - ratio one still routes through divider
// - driver powerdown resets to one
// - driver input mux selects three sources or none
// - slew disable removes all surge current
// - system clock source selects divider output/input
// - feedback divider ratio equals field plus one
// - reference divider ratio equals field plus one
// - pump polarity reverses control-node direction
// - pump full powerdown stops pump
// - quick powerdown gates only output buffer
// - pump current multiplier field plus one
module pdcw_clock_path
  import pdcw_pkg::*;
#(
  parameter int WORD_W = `PDCW_WORD_W,
  parameter int NBYTES = `PDCW_BYTES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // byte-wide write stream from the serial port, msb byte first
  input wire pdcw_wr_t wr_i,
  // pll status from the analog detector
  input wire logic pll_locked_i,
  input wire logic fb_lags_ref_i,
  // clock sources
  input wire logic rf_clock_input_i,
  input wire logic rf_div_clk_i,
  input wire logic feedback_clock_input_i,
  // shared sync-input/status pin
  output logic status_o,
  output logic status_oe_o,
  // read-back word and analog controls
  output logic [WORD_W-1:0] word_o,
  output pdcw_ctrl_t ctrl_o,
  output logic dds_system_clock_sel_o,
  output logic drv_clk_o,
  output logic word_err_o
);

  // ---------------------------------------------------------------
  // byte assembly
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] shift_q;
  logic [3:0] cnt_q;
  logic [WORD_W-1:0] word_q;
  logic err_q;
  logic commit;
  logic short_frame;

  assign commit = wr_i.frame_end && (cnt_q == 4'(NBYTES));
  assign short_frame = wr_i.frame_end && (cnt_q != 4'(NBYTES));

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      shift_q <= '0;
    end
    else if (wr_i.byte_vld && !wr_i.frame_end && cnt_q < 4'(NBYTES))
    begin
      shift_q <= {shift_q[WORD_W-9:0], wr_i.data};
    end
  end

  // frame end wins over a byte in the same cycle; extra bytes are ignored
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q <= '0;
    end
    else if (wr_i.frame_end)
    begin
      cnt_q <= '0;
    end
    else if (wr_i.byte_vld && cnt_q < 4'(NBYTES))
    begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // partial writes are discarded: the word changes only on a full five-byte frame
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      word_q <= `PDCW_RESET_VALUE;
    end
    else if (commit)
    begin
      word_q <= shift_q & `PDCW_IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      err_q <= 1'b0;
    end
    else if (short_frame)
    begin
      err_q <= 1'b1;
    end
    else if (commit)
    begin
      err_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic [4:0] fb_ratio;
  logic [4:0] ref_ratio;
  logic [3:0] cp_mult;

  pdcw_ratio_dec #(
    .CODE_W(4)
  ) u_fb_dec (
    .code_i(word_q[`PDCW_FB_DIV_HI:`PDCW_FB_DIV_LO]),
    .ratio_o(fb_ratio)
  );

  pdcw_ratio_dec #(
    .CODE_W(4)
  ) u_ref_dec (
    .code_i(word_q[`PDCW_REF_DIV_HI:`PDCW_REF_DIV_LO]),
    .ratio_o(ref_ratio)
  );

  pdcw_ratio_dec #(
    .CODE_W(3)
  ) u_cp_dec (
    .code_i(word_q[`PDCW_CP_SCALE_HI:`PDCW_CP_SCALE_LO]),
    .ratio_o(cp_mult)
  );

  // ---------------------------------------------------------------
  // analog and slew controls
  // ---------------------------------------------------------------
  logic [2:0] rise_boost;
  logic [2:0] fall_boost;
  logic surge_en;

  always_comb
  begin
    surge_en = ~word_q[`PDCW_SLEW_DIS_BIT];
    // slew disable also drops the default surges, so the boost bits go too
    rise_boost = word_q[`PDCW_RISE_HI:`PDCW_RISE_LO] & {3{surge_en}};
    fall_boost = word_q[`PDCW_FALL_HI:`PDCW_FALL_LO] & {3{surge_en}};
  end

  // ---------------------------------------------------------------
  // rf divider and system clock source
  // ---------------------------------------------------------------
  pdcw_rdiv_t rdiv;
  logic [3:0] rf_ratio;
  logic sys_bypass;

  always_comb
  begin
    rdiv = pdcw_rdiv_t'(word_q[`PDCW_RFDIV_HI:`PDCW_RFDIV_LO]);
    // ratio one keeps the divider in the path
    unique case (rdiv)
      PDCW_RDIV_8: rf_ratio = 4'h8;
      PDCW_RDIV_4: rf_ratio = 4'h4;
      PDCW_RDIV_2: rf_ratio = 4'h2;
      PDCW_RDIV_1: rf_ratio = 4'h1;
    endcase
    // a powered-down divider hands the system clock to the alternate path
    sys_bypass = word_q[`PDCW_SYS_SRC_BIT] | word_q[`PDCW_RFDIV_PD_BIT];
  end

  // ---------------------------------------------------------------
  // clock driver enable
  // ---------------------------------------------------------------
  pdcw_drv_sel_t dsel;
  logic drv_run;

  always_comb
  begin
    dsel = pdcw_drv_sel_t'(word_q[`PDCW_DRV_SEL_HI:`PDCW_DRV_SEL_LO]);
    // the driver runs only when powered up and fed from a source
    drv_run = ~word_q[`PDCW_DRV_PD_BIT] && (dsel != PDCW_DRV_NONE);
  end

  // ---------------------------------------------------------------
  // charge pump controls
  // ---------------------------------------------------------------
  logic cp_out_en;

  always_comb
  begin
    // either power-down gates the output buffer
    cp_out_en = ~word_q[`PDCW_CP_FULL_PD_BIT] & ~word_q[`PDCW_CP_QUICK_PD_BIT];
  end

  // ---------------------------------------------------------------
  // control bundle
  // ---------------------------------------------------------------
  pdcw_ctrl_t ctrl_d;

  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.dac_pd = word_q[`PDCW_DAC_PD_BIT];
    ctrl_d.bgap_pd = word_q[`PDCW_BGAP_PD_BIT];
    ctrl_d.int_rset = word_q[`PDCW_INT_RSET_BIT];
    ctrl_d.rise_boost = rise_boost;
    ctrl_d.fall_boost = fall_boost;
    ctrl_d.surge_en = surge_en;
    ctrl_d.rfdiv_pd = word_q[`PDCW_RFDIV_PD_BIT];
    ctrl_d.rf_ratio = rf_ratio;
    ctrl_d.drv_pd = word_q[`PDCW_DRV_PD_BIT];
    ctrl_d.drv_run = drv_run;
    ctrl_d.drv_sel = dsel;
    ctrl_d.sys_src_bypass = sys_bypass;
    ctrl_d.fb_ratio = fb_ratio;
    ctrl_d.ref_ratio = ref_ratio;
    ctrl_d.cp_invert = word_q[`PDCW_CP_POL_BIT];
    ctrl_d.cp_pd = word_q[`PDCW_CP_FULL_PD_BIT];
    ctrl_d.cp_out_en = cp_out_en;
    ctrl_d.cp_mult = cp_mult;
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_o <= '0;
    end
    else
    begin
      ctrl_o <= ctrl_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      word_o <= '0;
    end
    else
    begin
      word_o <= word_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      word_err_o <= 1'b0;
    end
    else
    begin
      word_err_o <= err_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dds_system_clock_sel_o <= 1'b0;
    end
    else
    begin
      dds_system_clock_sel_o <= sys_bypass;
    end
  end

  // ---------------------------------------------------------------
  // clock driver mux (registered sample of selected source)
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      drv_clk_o <= 1'b0;
    end
    else if (!ctrl_d.drv_run)
    begin
      drv_clk_o <= 1'b0;
    end
    else
    begin
      unique case (dsel)
        PDCW_DRV_NONE: drv_clk_o <= 1'b0;
        PDCW_DRV_FB: drv_clk_o <= feedback_clock_input_i;
        PDCW_DRV_RFOUT: drv_clk_o <= rf_div_clk_i;
        PDCW_DRV_RFIN: drv_clk_o <= rf_clock_input_i;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // lock detect output
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      status_oe_o <= 1'b0;
    end
    else
    begin
      status_oe_o <= word_q[`PDCW_LOCK_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      status_o <= 1'b0;
    end
    else if (!word_q[`PDCW_LOCK_EN_BIT])
    begin
      status_o <= 1'b0;
    end
    else if (word_q[`PDCW_LOCK_MODE_BIT])
    begin
      status_o <= fb_lags_ref_i;
    end
    else
    begin
      status_o <= ~pll_locked_i;
    end
  end

endmodule : pdcw_clock_path

// File: verif/pdcw_vco_model.sv
`timescale 1ns/1ns
// ------
// vco and loop filter stand-in
// ------
module pdcw_vco_model (
  input wire logic core_clk_i,
  input wire logic lock_req_i,
  output logic pll_locked_o,
  output logic fb_lags_ref_o,
  output logic fb_clk_o,
  output logic rf_clk_o,
  output logic rf_div_clk_o
);
  logic [3:0] ph_q = 4'h0;
  logic lock_q = 1'b0;
  always_ff @(posedge core_clk_i)
  begin
    ph_q <= ph_q + 4'h1;
    lock_q <= lock_req_i;
  end
  // phase relation swings between lead and lag every four cycles
  assign fb_lags_ref_o = ph_q[2];
  assign fb_clk_o = ph_q[1];
  assign rf_clk_o = ph_q[0];
  assign rf_div_clk_o = ph_q[3];
  assign pll_locked_o = lock_q;
endmodule : pdcw_vco_model

// File: verif/pdcw_clock_path_props.sv
`timescale 1ns/1ns
// ------
// clock path checks
// ------
module pdcw_clock_path_props
  import pdcw_pkg::*;
#(
  parameter int WORD_W = 40
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic pll_locked_i,
  input wire logic fb_lags_ref_i,
  input wire logic status_o,
  input wire logic status_oe_o,
  input wire logic [WORD_W-1:0] word_o,
  input wire pdcw_ctrl_t ctrl_o,
  input wire logic dds_system_clock_sel_o,
  input wire logic drv_clk_o,
  input wire logic word_err_o
);
  // outputs still hold their reset zeros at the first edge after release
  logic live_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      live_q <= 1'b0;
    end
    else
    begin
      live_q <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_oe; status_oe_o == word_o[25]; endproperty
  a_oe: assert property (p_oe) else $error("status enable wrong");
  property p_off; !word_o[25] |-> !status_o; endproperty
  a_off: assert property (p_off) else $error("status high while off");
  property p_lock; word_o[25:24] == 2'b10 |-> status_o == !$past(pll_locked_i); endproperty
  a_lock: assert property (p_lock) else $error("lock flag wrong");
  property p_lag; word_o[25:24] == 2'b11 |-> status_o == $past(fb_lags_ref_i); endproperty
  a_lag: assert property (p_lag) else $error("lead lag wrong");
  property p_rf;
    live_q |-> ctrl_o.rf_ratio == 4'h1 << word_o[22:21] &&
      dds_system_clock_sel_o == (word_o[16] | word_o[23]);
  endproperty
  a_rf: assert property (p_rf) else $error("rf path wrong");
  property p_div;
    live_q |-> ctrl_o.fb_ratio == {1'b0, word_o[15:12]} + 5'h01 &&
      ctrl_o.ref_ratio == {1'b0, word_o[11:8]} + 5'h01;
  endproperty
  a_div: assert property (p_div) else $error("divider ratio wrong");
  property p_cp;
    live_q |-> ctrl_o.cp_mult == {1'b0, word_o[2:0]} + 4'h1 && ctrl_o.cp_invert == word_o[5];
  endproperty
  a_cp: assert property (p_cp) else $error("pump scale wrong");
  property p_pd;
    live_q |-> ctrl_o.cp_out_en == !(word_o[4] | word_o[3]) && ctrl_o.cp_pd == word_o[4] &&
      ctrl_o.surge_en == !word_o[17];
  endproperty
  a_pd: assert property (p_pd) else $error("power control wrong");
  property p_drv; word_o[20] || word_o[19:18] == 2'b00 |-> !drv_clk_o; endproperty
  a_drv: assert property (p_drv) else $error("driver toggles while off");
  property p_hold; $rose(word_err_o) |-> $stable(word_o); endproperty
  a_hold: assert property (p_hold) else $error("short frame changed word");
  c_err: cover property (word_err_o);
  c_lag: cover property (word_o[25:24] == 2'b11 && status_o);
  c_drv: cover property (!word_o[20] && drv_clk_o);
endmodule : pdcw_clock_path_props

bind pdcw_clock_path pdcw_clock_path_props #(.WORD_W(WORD_W)) u_props (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .pll_locked_i(pll_locked_i),
  .fb_lags_ref_i(fb_lags_ref_i), .status_o(status_o), .status_oe_o(status_oe_o),
  .word_o(word_o), .ctrl_o(ctrl_o), .dds_system_clock_sel_o(dds_system_clock_sel_o),
  .drv_clk_o(drv_clk_o), .word_err_o(word_err_o));

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import pdcw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lock_req = 1'b0;
  pdcw_wr_t wr = '0;
  logic locked, lags, fb_clk, rf_clk, rf_div, status, oe, sys_sel, drv_clk, err;
  logic [39:0] word;
  pdcw_ctrl_t ctrl;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  // ------
  // clock, partner and block
  // ------
  initial forever #4 clk = ~clk;
  pdcw_vco_model u_vco (.core_clk_i(clk), .lock_req_i(lock_req), .pll_locked_o(locked),
    .fb_lags_ref_o(lags), .fb_clk_o(fb_clk), .rf_clk_o(rf_clk), .rf_div_clk_o(rf_div));
  pdcw_clock_path u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .wr_i(wr), .pll_locked_i(locked),
    .fb_lags_ref_i(lags), .rf_clock_input_i(rf_clk), .rf_div_clk_i(rf_div),
    .feedback_clock_input_i(fb_clk), .status_o(status), .status_oe_o(oe), .word_o(word),
    .ctrl_o(ctrl), .dds_system_clock_sel_o(sys_sel), .drv_clk_o(drv_clk), .word_err_o(err));
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // n bytes msb first, then frame end, then let the outputs settle
  task automatic send(input logic [39:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      wr <= {2'b10, w[39-8*i -: 8]};
      @(posedge clk);
    end
    wr <= {2'b01, 8'h00};
    @(posedge clk);
    wr <= '0;
    repeat (4) @(posedge clk);
  endtask : send
  task automatic results;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      mismatches++;
      results();
    end
  end
  // ------
  // scenarios
  // ------
  task automatic t_codes;
    logic [39:0] w;
    int rises;
    int want;
    logic prev;
    for (int c = 0; c < 4; c++)
    begin
      w = {17'h0, c[1:0], 1'b0, c[1:0], 18'h0};
      send(w, 5);
      chk("word", w, word);
      chk("rf_ratio", 40'h1 << c, ctrl.rf_ratio);
      chk("drv_sel", 40'(c), ctrl.drv_sel);
      chk("sys_sel", 40'h0, sys_sel);
      chk("drv_run", 40'(c != 0), ctrl.drv_run);
      // rising edges in 16 cycles: none, feedback /4, divider out /16, divider in /2
      want = (c == 0) ? 0 : (c == 1) ? 4 : (c == 2) ? 1 : 8;
      rises = 0;
      prev = drv_clk;
      repeat (16)
      begin
        @(posedge clk);
        rises += (drv_clk && !prev) ? 1 : 0;
        prev = drv_clk;
      end
      chk("drv_rises", 40'(want), 40'(rises));
    end
    $display("codes test done");
  endtask : t_codes
  task automatic t_fields;
    send(40'h00_0083_ff3f, 5);
    chk("fb_ratio", 40'h10, ctrl.fb_ratio);
    chk("ref_ratio", 40'h10, ctrl.ref_ratio);
    chk("cp_mult", 40'h8, ctrl.cp_mult);
    chk("cp_flags", 40'h6, {ctrl.cp_invert, ctrl.cp_pd, ctrl.cp_out_en});
    chk("surge_en", 40'h0, ctrl.surge_en);
    chk("bypass", 40'h3, {ctrl.rfdiv_pd, sys_sel});
    send(40'h00_0001_0008, 5);
    chk("cp_flags", 40'h0, {ctrl.cp_invert, ctrl.cp_pd, ctrl.cp_out_en});
    chk("sys_sel", 40'h1, sys_sel);
    send(40'h83_fc00_0000, 5);
    chk("pd_rset", 40'h7, {ctrl.dac_pd, ctrl.bgap_pd, ctrl.int_rset});
    chk("boost", 40'h3f, {ctrl.rise_boost, ctrl.fall_boost});
    send(40'h83_fc02_0000, 5);
    chk("boost_off", 40'h0, {ctrl.rise_boost, ctrl.fall_boost, ctrl.surge_en});
    $display("fields test done");
  endtask : t_fields
  task automatic t_status;
    logic prev;
    send(40'h00_0200_0000, 5);
    lock_req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("oe", 40'h1, oe);
    chk("locked", 40'h0, status);
    lock_req <= 1'b0;
    repeat (4) @(posedge clk);
    chk("unlocked", 40'h1, status);
    send(40'h00_0300_0000, 5);
    prev = lags;
    repeat (8)
    begin
      @(posedge clk);
      chk("lead_lag", 40'(prev), 40'(status));
      prev = lags;
    end
    send(40'h0, 5);
    chk("off", 40'h0, {oe, status});
    $display("status test done");
  endtask : t_status
  task automatic t_short;
    send(40'h80_0000_0000, 4);
    chk("kept", 40'h0, word);
    chk("err", 40'h1, err);
    send(40'h00_0000_0004, 5);
    chk("err", 40'h0, err);
    chk("cp_mult", 40'h5, ctrl.cp_mult);
    $display("short frame test done");
  endtask : t_short
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("word", 40'h00_0078_0000, word);
    chk("drv", 40'h1c, {ctrl.rf_ratio[3], ctrl.drv_pd, ctrl.drv_sel, oe});
    $display("reset test done");
    t_codes();
    t_fields();
    t_status();
    t_short();
    results();
  end
endmodule : tb_top
